//--- core/adc_ctrl_regs.sv
// Configuration register group of a dual-channel converter: channel select,
// shadow commit, power mode, clock stabilizer, divider and test patterns.
// Assumes a serial port front end that presents one-cycle write and read
// strobes with an 8-bit address and data, synchronous to clk_sys_in.
//
// Summary of operation
// (R01) Select bits 1:0 pick channel B/A for writes; both set after reset.
// (R02) Selects steer per-channel registers only; global writes ignore them.
// (R03) Power bit 5: 0 makes power-down pin full power-down, 1 standby.
// (R04) Clock divide bits 2:0 divide input clock by field plus one.
// (R05) Test bit 7: 0 repeats pattern, 1 shows it once then zeros.
// (R06) Any selected test mode replaces converted samples on the outputs.
// (R07) Pattern code 0101 gives long sequence, 0110 short; others unused.
// (R08) Nonzero divide ratio forces stabilizer on; enable bit resets to one.
// (R09) Shadow copies apply only on a 0x01 commit write; commit self-clears.
// (R10) Per-channel read with both selects set returns channel A value.
`timescale 1ns/1ps
`default_nettype none
module adc_ctrl_regs #(
    parameter int DATA_W = 14
) (
    input  wire logic              clk_sys_in,
    input  wire logic              rstn_in,
    input  wire logic              wr_strobe_in,
    input  wire logic              rd_strobe_in,
    input  wire logic [7:0]        addr_in,
    input  wire logic [7:0]        wdata_in,
    output logic [7:0]             rdata_out,
    input  wire logic              pdn_pin_in,
    input  wire logic              clk_in_edge_in,
    input  wire logic [DATA_W-1:0] sample_a_in,
    input  wire logic [DATA_W-1:0] sample_b_in,
    output logic [DATA_W-1:0]      data_a_out,
    output logic [DATA_W-1:0]      data_b_out,
    output logic [1:0]             powerdown_out,
    output logic [1:0]             standby_out,
    output logic                   stabilizer_on_out,
    output logic [2:0]             div_ratio_out,
    output logic [2:0]             div_phase_out,
    output logic                   conv_clk_out
);
    // Shadow (master) copies written by the port, live (slave) copies used.
    logic [7:0] channel_select_reg;
    logic [7:0] power_mode_sh_reg [2];
    logic [7:0] power_mode_reg    [2];
    logic [7:0] clock_global_sh_reg;
    logic [7:0] clock_global_reg;
    logic [7:0] clock_divider_sh_reg;
    logic [7:0] clock_divider_reg;
    logic [7:0] test_pattern_sh_reg [2];
    logic [7:0] test_pattern_reg    [2];
    logic       commit_reg;
    logic       commit_next;

    logic wr_chsel;
    logic wr_pwr;
    logic wr_glob;
    logic wr_div;
    logic wr_test;
    logic wr_commit;

    assign wr_chsel  = wr_strobe_in
                       && addr_in == adc_ctrl_pkg::addr_channel_select;
    assign wr_pwr    = wr_strobe_in && addr_in == adc_ctrl_pkg::addr_power_mode;
    assign wr_glob   = wr_strobe_in
                       && addr_in == adc_ctrl_pkg::addr_clock_global;
    assign wr_div    = wr_strobe_in
                       && addr_in == adc_ctrl_pkg::addr_clock_divider;
    assign wr_test   = wr_strobe_in
                       && addr_in == adc_ctrl_pkg::addr_test_pattern;
    assign wr_commit = wr_strobe_in
                       && addr_in == adc_ctrl_pkg::addr_shadow_commit
                       && wdata_in == adc_ctrl_pkg::commit_value;

    always_ff @(posedge clk_sys_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            channel_select_reg <= adc_ctrl_pkg::rst_channel_select; // [R01]
        end
        else if (wr_chsel)
        begin
            channel_select_reg <= {6'h00, wdata_in[1:0]}; // [R01]
        end
    end

    // Shadow writes: per-channel copies follow the select bits, the
    // chip-wide ones do not look at them.
    always_ff @(posedge clk_sys_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            for (int c = 0; c < 2; c++)
            begin
                power_mode_sh_reg[c]   <= adc_ctrl_pkg::rst_power_mode;
                test_pattern_sh_reg[c] <= adc_ctrl_pkg::rst_test_pattern;
            end
            clock_global_sh_reg  <= adc_ctrl_pkg::rst_clock_global; // [R08]
            clock_divider_sh_reg <= adc_ctrl_pkg::rst_clock_divider; // [R04]
        end
        else
        begin
            for (int c = 0; c < 2; c++)
            begin
                if (wr_pwr && channel_select_reg[c]) // [R01] [R02]
                begin
                    power_mode_sh_reg[c] <= wdata_in & 8'h23;
                end
                if (wr_test && channel_select_reg[c]) // [R01] [R02]
                begin
                    test_pattern_sh_reg[c] <= wdata_in & 8'hbf;
                end
            end
            if (wr_glob) // [R02]
            begin
                clock_global_sh_reg <= wdata_in & 8'h01;
            end
            if (wr_div) // [R02]
            begin
                clock_divider_sh_reg <= wdata_in & 8'h3f;
            end
        end
    end

    // The commit bit is observable for one cycle, then clears itself.
    assign commit_next = wr_commit;

    always_ff @(posedge clk_sys_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            commit_reg <= 1'b0;
        end
        else
        begin
            commit_reg <= commit_next; // [R09]
        end
    end

    always_ff @(posedge clk_sys_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            for (int c = 0; c < 2; c++)
            begin
                power_mode_reg[c]   <= adc_ctrl_pkg::rst_power_mode;
                test_pattern_reg[c] <= adc_ctrl_pkg::rst_test_pattern;
            end
            clock_global_reg  <= adc_ctrl_pkg::rst_clock_global;
            clock_divider_reg <= adc_ctrl_pkg::rst_clock_divider;
        end
        else if (commit_reg) // [R09]
        begin
            power_mode_reg    <= power_mode_sh_reg;
            test_pattern_reg  <= test_pattern_sh_reg;
            clock_global_reg  <= clock_global_sh_reg;
            clock_divider_reg <= clock_divider_sh_reg;
        end
    end

    // Read back returns shadow values so the host sees what it wrote.
    always_ff @(posedge clk_sys_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            rdata_out <= 8'h00;
        end
        else if (rd_strobe_in)
        begin
            if (addr_in == adc_ctrl_pkg::addr_channel_select)
                rdata_out <= channel_select_reg;
            else if (addr_in == adc_ctrl_pkg::addr_power_mode) // [R10]
                rdata_out <= channel_select_reg[0] ? power_mode_sh_reg[0]
                                                   : power_mode_sh_reg[1];
            else if (addr_in == adc_ctrl_pkg::addr_clock_global)
                rdata_out <= clock_global_sh_reg;
            else if (addr_in == adc_ctrl_pkg::addr_clock_divider)
                rdata_out <= clock_divider_sh_reg;
            else if (addr_in == adc_ctrl_pkg::addr_test_pattern) // [R10]
                rdata_out <= channel_select_reg[0] ? test_pattern_sh_reg[0]
                                                   : test_pattern_sh_reg[1];
            else if (addr_in == adc_ctrl_pkg::addr_shadow_commit)
                rdata_out <= {7'h00, commit_reg};
            else
                rdata_out <= 8'h00;
        end
    end

    // Power-down pin function per channel.
    always_ff @(posedge clk_sys_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            powerdown_out <= 2'b00;
            standby_out   <= 2'b00;
        end
        else
        begin
            for (int c = 0; c < 2; c++)
            begin
                powerdown_out[c] <= pdn_pin_in // [R03]
                    && !power_mode_reg[c][adc_ctrl_pkg::pos_pdn_pin_standby];
                standby_out[c]   <= pdn_pin_in // [R03]
                    && power_mode_reg[c][adc_ctrl_pkg::pos_pdn_pin_standby];
            end
        end
    end

    // Clock divider: clk_in_edge_in marks each input clock edge.
    logic [2:0] div_cnt_reg;
    logic [2:0] ratio;
    assign ratio = clock_divider_reg[adc_ctrl_pkg::pos_div_ratio_lsb +: 3];

    always_ff @(posedge clk_sys_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            div_cnt_reg  <= 3'h0;
            conv_clk_out <= 1'b0;
        end
        else if (clk_in_edge_in)
        begin
            conv_clk_out <= div_cnt_reg == 3'h0; // [R04]
            div_cnt_reg  <= (div_cnt_reg >= ratio) ? 3'h0
                                                   : div_cnt_reg + 3'h1; // [R04]
        end
    end

    always_ff @(posedge clk_sys_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            stabilizer_on_out <= 1'b1;
            div_ratio_out     <= 3'h0;
            div_phase_out     <= 3'h0;
        end
        else
        begin
            stabilizer_on_out <= (ratio != 3'h0) || clock_global_reg[
                adc_ctrl_pkg::pos_stabilizer_enable]; // [R08]
            div_ratio_out <= ratio;
            div_phase_out <=
                clock_divider_reg[adc_ctrl_pkg::pos_div_phase_lsb +: 3];
        end
    end

    // Pattern generators and output selection, one set per channel.
    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : chan
            logic [3:0]  sel;
            logic        active;
            logic        shot_done_reg;
            logic [22:0] long_state;
            logic [8:0]  short_state;
            logic        moved_reg;
            logic        at_seed;

            assign sel    = test_pattern_reg[g][adc_ctrl_pkg::pos_pattern_sel_lsb +: 4];
            assign active = sel != adc_ctrl_pkg::pat_off; // [R06]
            assign at_seed = (sel == adc_ctrl_pkg::pat_long_prbs)
                ? long_state == adc_ctrl_pkg::seed_long_prbs
                : short_state == adc_ctrl_pkg::seed_short_prbs;

            prbs_gen #(
                .WIDTH (23),
                .TAP_A (22),
                .TAP_B (17),
                .SEED  (adc_ctrl_pkg::seed_long_prbs)
            ) long_gen (
                .clk_sys_in (clk_sys_in),
                .rstn_in    (rstn_in),
                .reload_in  (test_pattern_reg[g][adc_ctrl_pkg::pos_reset_long_gen]
                             || !active),
                .step_in    (sel == adc_ctrl_pkg::pat_long_prbs), // [R07]
                .state_out  (long_state)
            );

            prbs_gen #(
                .WIDTH (9),
                .TAP_A (8),
                .TAP_B (4),
                .SEED  (adc_ctrl_pkg::seed_short_prbs)
            ) short_gen (
                .clk_sys_in (clk_sys_in),
                .rstn_in    (rstn_in),
                .reload_in  (test_pattern_reg[g][adc_ctrl_pkg::pos_reset_short_gen]
                             || !active),
                .step_in    (sel == adc_ctrl_pkg::pat_short_prbs), // [R07]
                .state_out  (short_state)
            );

            // A single-shot pattern ends when the sequence comes back to its
            // seed; the seed it starts from must not end it at once.
            always_ff @(posedge clk_sys_in or negedge rstn_in)
            begin
                if (!rstn_in)
                    {moved_reg, shot_done_reg} <= 2'b00;
                else if (!active || commit_reg)
                    {moved_reg, shot_done_reg} <= 2'b00;
                else
                begin
                    moved_reg <= moved_reg || !at_seed;
                    if (moved_reg && at_seed
                        && test_pattern_reg[g][adc_ctrl_pkg::pos_single_shot])
                        shot_done_reg <= 1'b1; // [R05]
                end
            end

            logic [DATA_W-1:0] pat;
            always_comb
            begin
                pat = '0;
                if (shot_done_reg) // [R05]
                    pat = '0;
                else if (sel == adc_ctrl_pkg::pat_long_prbs)
                    pat = long_state[DATA_W-1:0]; // [R07]
                else if (sel == adc_ctrl_pkg::pat_short_prbs)
                    pat = {{(DATA_W-9){1'b0}}, short_state}; // [R07]
            end

            logic [DATA_W-1:0] out_reg;
            always_ff @(posedge clk_sys_in or negedge rstn_in)
            begin
                if (!rstn_in)
                    out_reg <= '0;
                else
                    out_reg <= active ? pat
                               : (g == 0 ? sample_a_in : sample_b_in); // [R06]
            end
        end
    endgenerate

    assign data_a_out = chan[0].out_reg;
    assign data_b_out = chan[1].out_reg;
endmodule
`default_nettype wire

//--- core/adc_ctrl_pkg.sv
// Constants for the dual converter configuration register group.
// Assumes an 8-bit register access port driven by a serial port front end.
package adc_ctrl_pkg;
    localparam logic [7:0] addr_channel_select  = 8'h05;
    localparam logic [7:0] addr_power_mode      = 8'h08;
    localparam logic [7:0] addr_clock_global    = 8'h09;
    localparam logic [7:0] addr_clock_divider   = 8'h0b;
    localparam logic [7:0] addr_test_pattern    = 8'h0d;
    localparam logic [7:0] addr_shadow_commit   = 8'hff;

    localparam logic [7:0] rst_channel_select   = 8'h03;
    localparam logic [7:0] rst_power_mode       = 8'h00;
    localparam logic [7:0] rst_clock_global     = 8'h01;
    localparam logic [7:0] rst_clock_divider    = 8'h00;
    localparam logic [7:0] rst_test_pattern     = 8'h00;
    localparam logic [7:0] commit_value         = 8'h01;

    localparam int pos_pdn_pin_standby   = 5;
    localparam int pos_pdn_mode_lsb      = 0;
    localparam int pos_stabilizer_enable = 0;
    localparam int pos_div_ratio_lsb     = 0;
    localparam int pos_div_phase_lsb     = 3;
    localparam int pos_single_shot       = 7;
    localparam int pos_reset_long_gen    = 5;
    localparam int pos_reset_short_gen   = 4;
    localparam int pos_pattern_sel_lsb   = 0;

    localparam logic [3:0] pat_off        = 4'h0;
    localparam logic [3:0] pat_long_prbs  = 4'h5;
    localparam logic [3:0] pat_short_prbs = 4'h6;

    localparam logic [22:0] seed_long_prbs  = 23'h7fffff;
    localparam logic [8:0]  seed_short_prbs = 9'h1ff;
endpackage

//--- core/prbs_gen.sv
// Parameterised pseudorandom sequence generator (Fibonacci LFSR).
// Assumes the caller decides when to step and when to reload the seed.
`timescale 1ns/1ps
`default_nettype none
module prbs_gen #(
    parameter int          WIDTH = 9,
    parameter int          TAP_A = 8,
    parameter int          TAP_B = 4,
    parameter logic [WIDTH-1:0] SEED = '1
) (
    input  wire logic             clk_sys_in,
    input  wire logic             rstn_in,
    input  wire logic             reload_in,
    input  wire logic             step_in,
    output logic [WIDTH-1:0]      state_out
);
    logic [WIDTH-1:0] lfsr_reg;

    always_ff @(posedge clk_sys_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            lfsr_reg <= SEED;
        end
        else if (reload_in)
        begin
            lfsr_reg <= SEED;
        end
        else if (step_in)
        begin
            lfsr_reg <= {lfsr_reg[WIDTH-2:0],
                         lfsr_reg[TAP_A] ^ lfsr_reg[TAP_B]};
        end
    end

    assign state_out = lfsr_reg;
endmodule
`default_nettype wire

//--- testbench/adc_ctrl_regs_chk.sv
// Concurrent checks on the converter register group's ports.
// Assumes binding to adc_ctrl_regs with one clock and async low reset.
`timescale 1ns/1ps
`default_nettype none
module adc_ctrl_regs_chk (
    input wire logic       clk_sys_in,
    input wire logic       rstn_in,
    input wire logic       wr_strobe_in,
    input wire logic       rd_strobe_in,
    input wire logic [7:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic [7:0] rdata_out,
    input wire logic       clk_in_edge_in,
    input wire logic       stabilizer_on_out,
    input wire logic [2:0] div_ratio_out,
    input wire logic [2:0] div_phase_out,
    input wire logic       conv_clk_out
);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rstn_in);
    logic [3:0] since_cm;
    // Saturating age of the last commit write.
    always_ff @(posedge clk_sys_in or negedge rstn_in)
    begin
        if (!rstn_in)
            since_cm <= 4'hf;
        else if (wr_strobe_in && addr_in == 8'hff && wdata_in == 8'h01)
            since_cm <= 4'h0;
        else if (since_cm != 4'hf)
            since_cm <= since_cm + 4'h1;
    end
    AST_STAB_FORCE: assert property (
        div_ratio_out != 3'h0 |-> stabilizer_on_out)
        else $error("stabilizer off with nonzero divide");
    AST_RESET_VAL: assert property (
        $rose(rstn_in) |-> stabilizer_on_out && div_ratio_out == 3'h0)
        else $error("divider outputs wrong after reset");
    AST_NO_COMMIT: assert property (
        $changed(div_ratio_out) || $changed(div_phase_out)
        |-> since_cm <= 4'h6)
        else $error("divider changed without commit");
    AST_RD_UNMAPPED: assert property (
        rd_strobe_in && !(addr_in inside {8'h05, 8'h08, 8'h09,
        8'h0b, 8'h0d, 8'hff}) |=> rdata_out == 8'h00)
        else $error("unmapped read not zero");
    AST_RD_STABLE: assert property (
        !rd_strobe_in |=> $stable(rdata_out))
        else $error("read data moved without read");
    AST_RD_CHSEL: assert property (
        rd_strobe_in && addr_in == 8'h05 |=> rdata_out[7:2] == 6'h00)
        else $error("channel select reserved bits set");
    AST_RD_GCLK: assert property (
        rd_strobe_in && addr_in == 8'h09 |=> rdata_out[7:1] == 7'h00)
        else $error("global clock reserved bits set");
    AST_RD_DIV: assert property (
        rd_strobe_in && addr_in == 8'h0b |=> rdata_out[7:6] == 2'h0)
        else $error("divider reserved bits set");
    AST_CONV_EDGE: assert property (
        $changed(conv_clk_out) |-> $past(clk_in_edge_in))
        else $error("divided clock moved off input edge");
endmodule
bind adc_ctrl_regs adc_ctrl_regs_chk u_chk (
    .clk_sys_in, .rstn_in, .wr_strobe_in, .rd_strobe_in, .addr_in,
    .wdata_in, .rdata_out, .clk_in_edge_in, .stabilizer_on_out,
    .div_ratio_out, .div_phase_out, .conv_clk_out);
`default_nettype wire

//--- testbench/cfg_host.sv
// Host model issuing single-byte register writes and reads.
// Assumes the register group's one-cycle strobes on clk_sys_in.
`timescale 1ns/1ps
`default_nettype none
module cfg_host (
    input  wire logic       clk_sys_in,
    input  wire logic [7:0] rdata_in,
    output var logic        wr_strobe_out = 1'b0,
    output var logic        rd_strobe_out = 1'b0,
    output var logic [7:0]  addr_out = 8'h00,
    output var logic [7:0]  wdata_out = 8'h00
);
    // Idle address and data show the inverse so stale values never match.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_in);
        wr_strobe_out <= 1'b1;
        addr_out <= a;
        wdata_out <= d;
        @(posedge clk_sys_in);
        wr_strobe_out <= 1'b0;
        addr_out <= ~a;
        wdata_out <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys_in);
        rd_strobe_out <= 1'b1;
        addr_out <= a;
        @(posedge clk_sys_in);
        rd_strobe_out <= 1'b0;
        addr_out <= ~a;
        @(posedge clk_sys_in);
        d = rdata_in;
    endtask
endmodule
`default_nettype wire

//--- testbench/test_dual_adc_control_registers.sv
// Self-checking bench for the converter register group.
// Assumes cfg_host for register access and a free-running edge marker.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin \
    miscompares++; $display("unexpected at %0t: %h vs %h", $time, \
    (a), (b)); end end
module test_dual_adc_control_registers;
    logic        clk_sys_in = 1'b0;
    logic        rstn_in = 1'b0;
    logic        pdn_pin_in = 1'b0;
    logic        clk_in_edge_in = 1'b1;
    logic [13:0] sample_a_in = 14'h2aaa;
    logic [13:0] sample_b_in = 14'h1555;
    wire logic   wr_s;
    wire logic   rd_s;
    wire logic [7:0] addr;
    wire logic [7:0] wdata;
    logic [7:0]  rdata;
    logic [7:0]  rv;
    logic [13:0] da, db;
    logic [1:0]  pd, sb;
    logic        stab, conv, conv_q;
    logic [2:0]  ratio, phase;
    int          miscompares = 0;
    int          checks_done = 0;
    int          rises = 0;
    logic [7:0]  ra [7] = '{8'h05, 8'h08, 8'h09, 8'h0b, 8'h0d, 8'hff,
                             8'h13};
    logic [7:0]  rr [7] = '{8'h03, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00,
                             8'h00};
    always #5 clk_sys_in = ~clk_sys_in;
    // Input clock edges come every other cycle, so the divider sees gaps.
    always @(posedge clk_sys_in)
        clk_in_edge_in <= ~clk_in_edge_in;
    always @(posedge clk_sys_in)
    begin
        conv_q <= conv;
        if (conv && !conv_q)
            rises++;
    end
    cfg_host u_host (.clk_sys_in(clk_sys_in), .rdata_in(rdata),
        .wr_strobe_out(wr_s), .rd_strobe_out(rd_s), .addr_out(addr),
        .wdata_out(wdata));
    adc_ctrl_regs DUT (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in),
        .wr_strobe_in(wr_s), .rd_strobe_in(rd_s), .addr_in(addr),
        .wdata_in(wdata), .rdata_out(rdata), .pdn_pin_in(pdn_pin_in),
        .clk_in_edge_in(clk_in_edge_in), .sample_a_in(sample_a_in),
        .sample_b_in(sample_b_in), .data_a_out(da), .data_b_out(db),
        .powerdown_out(pd), .standby_out(sb),
        .stabilizer_on_out(stab), .div_ratio_out(ratio),
        .div_phase_out(phase), .conv_clk_out(conv));
    task automatic give_verdict;
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        u_host.rd(a, rv);
        `CHK(rv, e)
    endtask
    // Settle time covers the commit pipeline of a few cycles.
    task automatic commit;
        u_host.wr(8'hff, 8'h01);
        repeat (6) @(posedge clk_sys_in);
    endtask
    task automatic rate(input int lo, input int hi);
        rises = 0;
        repeat (240) @(posedge clk_sys_in);
        `CHK(rises >= lo && rises <= hi, 1'b1)
    endtask
    initial
    begin
        #200us;
        miscompares++;
        give_verdict;
    end
    initial
    begin
        repeat (2) @(posedge clk_sys_in);
        rstn_in <= 1'b1;
        for (int i = 0; i < 7; i++)
            rdchk(ra[i], rr[i]);
        `CHK(stab, 1'b1)
        u_host.wr(8'h13, 8'hff);
        rdchk(8'h13, 8'h00);
        u_host.wr(8'h0b, 8'h02);
        u_host.wr(8'h09, 8'h00);
        u_host.wr(8'hff, 8'h02);
        repeat (8) @(posedge clk_sys_in);
        `CHK(ratio, 3'h0)
        commit;
        `CHK(ratio, 3'h2)
        `CHK(stab, 1'b1)
        rdchk(8'hff, 8'h00);
        rate(39, 41);
        u_host.wr(8'h0b, 8'h07);
        commit;
        rate(14, 16);
        u_host.wr(8'h0b, 8'h00);
        commit;
        `CHK(stab, 1'b0)
        u_host.wr(8'h05, 8'h01);
        u_host.wr(8'h08, 8'h20);
        commit;
        pdn_pin_in <= 1'b1;
        repeat (3) @(posedge clk_sys_in);
        `CHK(sb, 2'b01)
        `CHK(pd, 2'b10)
        u_host.wr(8'h05, 8'h03);
        rdchk(8'h08, 8'h20);
        u_host.wr(8'h05, 8'h02);
        rdchk(8'h08, 8'h00);
        u_host.wr(8'h0b, 8'h19);
        commit;
        `CHK(ratio, 3'h1)
        `CHK(phase, 3'h3)
        pdn_pin_in <= 1'b0;
        u_host.wr(8'h0d, 8'h05);
        commit;
        `CHK(da, sample_a_in)
        `CHK(db !== sample_b_in, 1'b1)
        u_host.wr(8'h05, 8'h01);
        u_host.wr(8'h0d, 8'h86);
        commit;
        `CHK(da !== 14'h0000 && da !== sample_a_in, 1'b1)
        repeat (2000) @(posedge clk_sys_in);
        `CHK(da, 14'h0000)
        u_host.wr(8'h0d, 8'h06);
        commit;
        repeat (20) @(posedge clk_sys_in);
        `CHK(da !== 14'h0000 && da !== sample_a_in, 1'b1)
        u_host.wr(8'h0d, 8'h00);
        commit;
        `CHK(da, sample_a_in)
        give_verdict;
    end
endmodule
`default_nettype wire
